// File: tce_consts.svh
// Offsets, write masks, reset values and field positions of the timer
// clear and interrupt enable block; definitions only.
`ifndef TCE_CONSTS_SVH
`define TCE_CONSTS_SVH

`define TCE_ADDR_CLR 12'h000
`define TCE_ADDR_IER0 12'h004
`define TCE_ADDR_IER1 12'h008
`define TCE_ADDR_IER2 12'h00C
`define TCE_ADDR_IER3 12'h010
`define TCE_ADDR_IER4 12'h014
`define TCE_ADDR_IER0B 12'h018
`define TCE_ADDR_IER5 12'h01C
`define TCE_ADDR_STAT 12'h020

`define TCE_RESET_BYTE 8'h00
`define TCE_CLR_WMASK 8'h07
`define TCE_IER_WMASK_CH0 8'h9F
`define TCE_IER_WMASK_CH12 8'hB3
`define TCE_IER_WMASK_CH3 8'h9F
`define TCE_IER_WMASK_CH4 8'hDF
`define TCE_IER0B_WMASK 8'h83
`define TCE_IER5_WMASK 8'h07

`define TCE_BIT_CONV 7
`define TCE_BIT_TROUGH 6
`define TCE_BIT_UNDER 5
`define TCE_BIT_OVER 4
`define TCE_BIT_MD 3
`define TCE_BIT_MC 2
`define TCE_BIT_MB 1
`define TCE_BIT_MA 0
`define TCE_BIT_CLR_U 2
`define TCE_BIT_CLR_V 1
`define TCE_BIT_CLR_W 0

`endif

// File: tce_pkg.sv
// Types shared by the timer clear and interrupt enable block.
// Assumes tce_consts.svh is available on the include path.
package tce_pkg;

	typedef struct packed {
		logic match_a_event;
		logic underflow_flag;
		logic overflow_flag;
		logic match_d_flag;
		logic match_c_flag;
		logic match_b_flag;
		logic match_a_flag;
	} tce_chan_flags_t;

	typedef struct packed {
		logic conv_start;
		logic underflow_irq;
		logic overflow_irq;
		logic match_d_irq;
		logic match_c_irq;
		logic match_b_irq;
		logic match_a_irq;
	} tce_chan_req_t;

	typedef struct packed {
		logic event_u;
		logic event_v;
		logic event_w;
		logic flag_u;
		logic flag_v;
		logic flag_w;
	} tce_ch5_in_t;

	typedef struct packed {
		logic clear_u;
		logic clear_v;
		logic clear_w;
		logic irq_u;
		logic irq_v;
		logic irq_w;
	} tce_ch5_out_t;

endpackage

// File: tce_irq_gate.sv
// Gating of one channel's status flags by its interrupt enable byte.
// Assumes flags and events come from the timer core on the same clock.
`timescale 1ns/1ps
`include "tce_consts.svh"
module tce_irq_gate
	import tce_pkg::*;
#(
	parameter int CH = 0
) (
	input wire logic [7:0] en,
	input wire tce_chan_flags_t flags,
	output logic [7:0] wmask,
	output tce_chan_req_t req
);
	always_comb begin
		case (CH)
			0: wmask = `TCE_IER_WMASK_CH0;
			1, 2: wmask = `TCE_IER_WMASK_CH12;
			3: wmask = `TCE_IER_WMASK_CH3;
			default: wmask = `TCE_IER_WMASK_CH4;
		endcase
	end

	// Enable bits are already masked, so reserved positions gate nothing
	always_comb begin
		req.conv_start = flags.match_a_event & en[`TCE_BIT_CONV];
		req.underflow_irq = flags.underflow_flag & en[`TCE_BIT_UNDER];
		req.overflow_irq = flags.overflow_flag & en[`TCE_BIT_OVER];
		req.match_d_irq = flags.match_d_flag & en[`TCE_BIT_MD];
		req.match_c_irq = flags.match_c_flag & en[`TCE_BIT_MC];
		req.match_b_irq = flags.match_b_flag & en[`TCE_BIT_MB];
		req.match_a_irq = flags.match_a_flag & en[`TCE_BIT_MA];
	end
endmodule

// File: tce_clr_gate.sv
// Counter clear requests and interrupt gating of the three-phase channel.
// Assumes match/capture events are one-cycle pulses from the timer core.
`timescale 1ns/1ps
`include "tce_consts.svh"
module tce_clr_gate
	import tce_pkg::*;
(
	input wire logic [7:0] clear_en,
	input wire logic [7:0] irq_en,
	input wire tce_ch5_in_t ch5_in,
	output tce_ch5_out_t ch5_out
);
	always_comb begin
		ch5_out.clear_u = ch5_in.event_u & clear_en[`TCE_BIT_CLR_U];
		ch5_out.clear_v = ch5_in.event_v & clear_en[`TCE_BIT_CLR_V];
		ch5_out.clear_w = ch5_in.event_w & clear_en[`TCE_BIT_CLR_W];
		ch5_out.irq_u = ch5_in.flag_u & irq_en[`TCE_BIT_CLR_U];
		ch5_out.irq_v = ch5_in.flag_v & irq_en[`TCE_BIT_CLR_V];
		ch5_out.irq_w = ch5_in.flag_w & irq_en[`TCE_BIT_CLR_W];
	end
endmodule

// File: tce_top.sv
// Timer clear enable and per-channel interrupt enable registers on APB.
// Assumes status flags and event pulses arrive on pclk from the timer core.
//
// Operation
// - One 8-bit clear enable register for channel 5; bits 7..3 read zero.
// - Clear-enable bit 2 lets a U match or capture clear counter U.
// - Clear-enable bit 1 lets a V match or capture clear counter V.
// - Clear-enable bit 0 lets a W match or capture clear counter W.
// - Seven interrupt enable registers: two for channel 0, one each for 1..5.
// - Bit 7 in channels 0..4 lets register A events start the converter.
// - Channel 4 bit 6 lets trough underflow start the converter.
// - Bit 6 is reserved and reads zero in channels 0..3.
// - Bit 5 in channels 1 and 2 passes the underflow flag as request.
// - Bit 5 is reserved and reads zero in channels 0, 3 and 4.
// - Bit 4 passes the overflow flag as an overflow request.
// - Bit 3 in channels 0, 3, 4 passes the D flag as request.
// - Bit 3 is reserved and reads zero in channels 1 and 2.
// - Bit 2 passes the C flag in channels 0, 3, 4; reserved in 1, 2.
// - Bits 1 and 0 pass the B and A flags as requests.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "tce_consts.svh"
module tce_top
	import tce_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire tce_chan_flags_t [4:0] chan_flags,
	input wire logic ch4_trough_event,
	input wire logic ch0_match_e_event,
	input wire logic ch0_match_e_flag,
	input wire logic ch0_match_f_flag,
	input wire tce_ch5_in_t ch5_in,
	output tce_chan_req_t [4:0] chan_req,
	output logic ch4_trough_conv_start,
	output logic ch0_match_e_conv_start,
	output logic ch0_match_e_irq,
	output logic ch0_match_f_irq,
	output tce_ch5_out_t ch5_out
);

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [7:0] clear_en;
		logic [4:0][7:0] ier;
		logic [7:0] ier0b;
		logic [7:0] ier5;
		logic [31:0] prdata;
		tce_chan_req_t [4:0] req;
		logic trough_conv;
		logic e_conv;
		logic e_irq;
		logic f_irq;
		tce_ch5_out_t ch5;
	} tce_state_t;

	tce_state_t state_reg;
	tce_state_t state_next;
	logic [4:0][7:0] wmask;
	tce_chan_req_t [4:0] gate_req;
	tce_ch5_out_t gate_ch5;
	logic setup;
	logic wr_acc;
	logic mapped;
	logic [7:0] wbyte;
	logic [31:0] rdata;
	logic [31:0] status_word;

	////////////////////////////////////////////////////////////////////////////
	// Per-channel gating

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_chan
			tce_irq_gate #(
				.CH(gi)
			) u_gate (
				.en(state_reg.ier[gi]),
				.flags(chan_flags[gi]),
				.wmask(wmask[gi]),
				.req(gate_req[gi])
			);
		end
	endgenerate

	tce_clr_gate u_clr (
		.clear_en(state_reg.clear_en),
		.irq_en(state_reg.ier5),
		.ch5_in(ch5_in),
		.ch5_out(gate_ch5)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB decode

	// Zero wait states; read data is captured in the setup cycle
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pwrite & pstrb[0];
	assign wbyte = pwdata[7:0];
	assign pready = 1'b1;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[2:0] = {state_reg.ch5.clear_u, state_reg.ch5.clear_v, state_reg.ch5.clear_w};
		for (int i = 0; i < 5; i++) begin
			status_word[3 + i] = state_reg.req[i].conv_start;
		end
		status_word[8] = state_reg.trough_conv;
		status_word[9] = state_reg.e_conv;
	end

	always_comb begin
		mapped = 1'b1;
		rdata = 32'h0000_0000;
		case (paddr)
			`TCE_ADDR_CLR: rdata[7:0] = state_reg.clear_en;
			`TCE_ADDR_IER0: rdata[7:0] = state_reg.ier[0];
			`TCE_ADDR_IER1: rdata[7:0] = state_reg.ier[1];
			`TCE_ADDR_IER2: rdata[7:0] = state_reg.ier[2];
			`TCE_ADDR_IER3: rdata[7:0] = state_reg.ier[3];
			`TCE_ADDR_IER4: rdata[7:0] = state_reg.ier[4];
			`TCE_ADDR_IER0B: rdata[7:0] = state_reg.ier0b;
			`TCE_ADDR_IER5: rdata[7:0] = state_reg.ier5;
			`TCE_ADDR_STAT: rdata = status_word;
			default: mapped = 1'b0;
		endcase
	end

	assign pslverr = psel & penable & ~mapped;

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		state_next = state_reg;
		if (setup && !pwrite) begin
			state_next.prdata = rdata;
		end
		if (wr_acc) begin
			// Reserved bits are masked off so they keep reading zero
			case (paddr)
				`TCE_ADDR_CLR: state_next.clear_en = wbyte & `TCE_CLR_WMASK;
				`TCE_ADDR_IER0: state_next.ier[0] = wbyte & wmask[0];
				`TCE_ADDR_IER1: state_next.ier[1] = wbyte & wmask[1];
				`TCE_ADDR_IER2: state_next.ier[2] = wbyte & wmask[2];
				`TCE_ADDR_IER3: state_next.ier[3] = wbyte & wmask[3];
				`TCE_ADDR_IER4: state_next.ier[4] = wbyte & wmask[4];
				`TCE_ADDR_IER0B: state_next.ier0b = wbyte & `TCE_IER0B_WMASK;
				`TCE_ADDR_IER5: state_next.ier5 = wbyte & `TCE_IER5_WMASK;
				default: state_next.ier5 = state_reg.ier5;
			endcase
		end
		state_next.req = gate_req;
		state_next.trough_conv = ch4_trough_event & state_reg.ier[4][`TCE_BIT_TROUGH];
		state_next.e_conv = ch0_match_e_event & state_reg.ier0b[`TCE_BIT_CONV];
		state_next.e_irq = ch0_match_e_flag & state_reg.ier0b[0];
		state_next.f_irq = ch0_match_f_flag & state_reg.ier0b[1];
		state_next.ch5 = gate_ch5;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign prdata = state_reg.prdata;
	assign chan_req = state_reg.req;
	assign ch4_trough_conv_start = state_reg.trough_conv;
	assign ch0_match_e_conv_start = state_reg.e_conv;
	assign ch0_match_e_irq = state_reg.e_irq;
	assign ch0_match_f_irq = state_reg.f_irq;
	assign ch5_out = state_reg.ch5;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_write(logic [11:0] a);
		psel && penable && pwrite && pstrb[0] && paddr == a;
	endsequence

	property p_clr_rsv;
		s_write(`TCE_ADDR_CLR) |=> state_reg.clear_en[7:3] == 5'h00;
	endproperty
	a_clr_rsv: assert property (p_clr_rsv) else $error("clear enable reserved bits set");

	property p_clr_u;
		ch5_in.event_u |=> ch5_out.clear_u == $past(state_reg.clear_en[2]);
	endproperty
	a_clr_u: assert property (p_clr_u) else $error("U clear request wrong");

	property p_clr_v;
		ch5_in.event_v && state_reg.clear_en[1] |=> ch5_out.clear_v;
	endproperty
	a_clr_v: assert property (p_clr_v) else $error("V clear request missing");

	property p_clr_w;
		!ch5_in.event_w || !state_reg.clear_en[0] |=> !ch5_out.clear_w;
	endproperty
	a_clr_w: assert property (p_clr_w) else $error("W clear request without cause");

	property p_ier0b_store;
		s_write(`TCE_ADDR_IER0B) |=> state_reg.ier0b == ($past(pwdata[7:0]) & 8'h83);
	endproperty
	a_ier0b_store: assert property (p_ier0b_store) else $error("second ch0 enable not stored");

	property p_conv2;
		chan_flags[2].match_a_event && state_reg.ier[2][7] |=> chan_req[2].conv_start;
	endproperty
	a_conv2: assert property (p_conv2) else $error("ch2 converter start missing");

	property p_trough;
		ch4_trough_conv_start |-> $past(ch4_trough_event) && $past(state_reg.ier[4][6]);
	endproperty
	a_trough: assert property (p_trough) else $error("trough start without cause");

	property p_rsv_b6;
		state_reg.ier[0][6] == 1'b0 && state_reg.ier[3][6] == 1'b0 && state_reg.ier[1][6] == 1'b0;
	endproperty
	a_rsv_b6: assert property (p_rsv_b6) else $error("reserved bit 6 set");

	property p_under1;
		chan_flags[1].underflow_flag && state_reg.ier[1][5] |=> chan_req[1].underflow_irq;
	endproperty
	a_under1: assert property (p_under1) else $error("ch1 underflow request missing");

	property p_rsv_b5;
		s_write(`TCE_ADDR_IER4) |=> !state_reg.ier[4][5] && !chan_req[4].underflow_irq;
	endproperty
	a_rsv_b5: assert property (p_rsv_b5) else $error("ch4 reserved bit 5 took effect");

	property p_over3;
		!chan_flags[3].overflow_flag |=> !chan_req[3].overflow_irq;
	endproperty
	a_over3: assert property (p_over3) else $error("ch3 overflow request without flag");

	property p_md0;
		chan_flags[0].match_d_flag && state_reg.ier[0][3] |=> chan_req[0].match_d_irq;
	endproperty
	a_md0: assert property (p_md0) else $error("ch0 D request missing");

	property p_rsv_b3;
		s_write(`TCE_ADDR_IER2) |=> state_reg.ier[2][3:2] == 2'b00;
	endproperty
	a_rsv_b3: assert property (p_rsv_b3) else $error("ch2 reserved bits 3..2 stored");

	property p_mb4;
		chan_req[4].match_b_irq |-> $past(chan_flags[4].match_b_flag) && $past(state_reg.ier[4][1]);
	endproperty
	a_mb4: assert property (p_mb4) else $error("ch4 B request without cause");

	property p_hold_off;
		!state_reg.ier[1][0] |=> !chan_req[1].match_a_irq;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("ch1 A request while disabled");

	property p_rd_clr;
		setup && !pwrite && paddr == `TCE_ADDR_CLR |=> prdata[31:3] == 29'h0000_0000;
	endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("reserved clear bits read nonzero");

	property p_clr_v_off;
		!state_reg.clear_en[1] |=> !ch5_out.clear_v;
	endproperty
	a_clr_v_off: assert property (p_clr_v_off) else $error("V clear while disabled");

	property p_ier3_store;
		s_write(`TCE_ADDR_IER3) |=> state_reg.ier[3] == ($past(pwdata[7:0]) & `TCE_IER_WMASK_CH3);
	endproperty
	a_ier3_store: assert property (p_ier3_store) else $error("ch3 enable not stored");

	property p_ier5_irq;
		ch5_in.flag_u && state_reg.ier5[2] |=> ch5_out.irq_u;
	endproperty
	a_ier5_irq: assert property (p_ier5_irq) else $error("U interrupt request missing");

	property p_e_conv;
		ch0_match_e_event && state_reg.ier0b[7] |=> ch0_match_e_conv_start;
	endproperty
	a_e_conv: assert property (p_e_conv) else $error("match E converter start missing");

	property p_f_irq;
		ch0_match_f_irq |-> $past(ch0_match_f_flag) && $past(state_reg.ier0b[1]);
	endproperty
	a_f_irq: assert property (p_f_irq) else $error("F request without cause");

	property p_trough_on;
		ch4_trough_event && state_reg.ier[4][6] |=> ch4_trough_conv_start;
	endproperty
	a_trough_on: assert property (p_trough_on) else $error("trough start missing");

	property p_under2_off;
		!state_reg.ier[2][5] |=> !chan_req[2].underflow_irq;
	endproperty
	a_under2_off: assert property (p_under2_off) else $error("ch2 underflow while disabled");

	property p_rsv_b5_all;
		!state_reg.ier[0][5] && !state_reg.ier[3][5] && !state_reg.ier[4][5];
	endproperty
	a_rsv_b5_all: assert property (p_rsv_b5_all) else $error("reserved bit 5 set");

	property p_over4;
		chan_flags[4].overflow_flag && state_reg.ier[4][4] |=> chan_req[4].overflow_irq;
	endproperty
	a_over4: assert property (p_over4) else $error("ch4 overflow request missing");

	property p_rsv_cd;
		state_reg.ier[1][3:2] == 2'b00 && state_reg.ier[2][3:2] == 2'b00;
	endproperty
	a_rsv_cd: assert property (p_rsv_cd) else $error("ch1/ch2 bits 3..2 set");

	property p_mc3;
		chan_flags[3].match_c_flag && state_reg.ier[3][2] |=> chan_req[3].match_c_irq;
	endproperty
	a_mc3: assert property (p_mc3) else $error("ch3 C request missing");

	property p_ma0;
		chan_req[0].match_a_irq |-> $past(chan_flags[0].match_a_flag) && $past(state_reg.ier[0][0]);
	endproperty
	a_ma0: assert property (p_ma0) else $error("ch0 A request without cause");

	c_clear_u: cover property (s_write(`TCE_ADDR_CLR) ##[1:20] ch5_out.clear_u);
	c_trough: cover property (ch4_trough_conv_start);
	c_under: cover property (chan_req[2].underflow_irq ##1 !chan_req[2].underflow_irq);
	c_slverr: cover property (pslverr);
	c_f_irq: cover property (ch0_match_f_irq);

endmodule

// File: timer_clear_and_irq_enable_tb.sv
// Self-checking bench for the timer clear and interrupt enable block.
// Assumes tce_pkg is compiled first and tce_consts.svh is on the include path.
`timescale 1ns/1ps
`include "tce_consts.svh"
module timer_clear_and_irq_enable_tb
	import tce_pkg::*;
;
logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rd;
logic [3:0] pstrb;
logic err;
tce_chan_flags_t [4:0] chan_flags;
tce_chan_req_t [4:0] chan_req;
logic ch4_trough_event, ch0_match_e_event, ch0_match_e_flag, ch0_match_f_flag;
logic ch4_trough_conv_start, ch0_match_e_conv_start, ch0_match_e_irq, ch0_match_f_irq;
tce_ch5_in_t ch5_in;
tce_ch5_out_t ch5_out;
int n_fail, samples_checked;
logic [11:0] addr_tab [8] = '{`TCE_ADDR_CLR, `TCE_ADDR_IER0, `TCE_ADDR_IER1, `TCE_ADDR_IER2,
	`TCE_ADDR_IER3, `TCE_ADDR_IER4, `TCE_ADDR_IER0B, `TCE_ADDR_IER5};
logic [7:0] mask_tab [8] = '{8'h07, 8'h9F, 8'hB3, 8'hB3, 8'h9F, 8'hDF, 8'h83, 8'h07};

tce_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .chan_flags(chan_flags),
	.ch4_trough_event(ch4_trough_event), .ch0_match_e_event(ch0_match_e_event),
	.ch0_match_e_flag(ch0_match_e_flag), .ch0_match_f_flag(ch0_match_f_flag),
	.ch5_in(ch5_in), .chan_req(chan_req), .ch4_trough_conv_start(ch4_trough_conv_start),
	.ch0_match_e_conv_start(ch0_match_e_conv_start), .ch0_match_e_irq(ch0_match_e_irq),
	.ch0_match_f_irq(ch0_match_f_irq), .ch5_out(ch5_out));

////////////////////////////////////////////////////////////////////////////////
initial begin
	pclk = 1'b0;
	forever #4 pclk = ~pclk;
end

task automatic close_out;
	if (n_fail == 0 && samples_checked > 0) begin
		$display("bench passed");
	end else begin
		$display("bench failed");
	end
	$finish;
endtask

task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
	samples_checked++;
	if (got !== exp) begin
		n_fail++;
		$display("unexpected %s: expected %h, seen %h", what, exp, got);
	end
endtask

// One APB transfer; holds the request until pready is sampled high or 16 cycles have passed
task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
	input logic [3:0] s);
	int n;
	@(posedge pclk);
	psel <= 1'b1;
	penable <= 1'b0;
	pwrite <= wr;
	paddr <= a;
	pwdata <= d;
	pstrb <= s;
	@(posedge pclk);
	penable <= 1'b1;
	n = 0;
	do begin
		@(posedge pclk);
		n++;
	end while (pready !== 1'b1 && n < 16);
	if (pready !== 1'b1) begin
		n_fail++;
		$display("unexpected pready: expected 1, seen %b", pready);
	end
	rd = prdata;
	err = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
endtask

task automatic settle;
	repeat (3) @(posedge pclk);
	#1;
endtask

////////////////////////////////////////////////////////////////////////////////
task automatic reset_values;
	for (int i = 0; i < 8; i++) begin
		apb(1'b0, addr_tab[i], 32'h0, 4'h0);
		chk("reset value", 32'h0, rd);
	end
	chk("requests after reset", '0, {chan_req, ch5_out, ch0_match_e_irq});
endtask

task automatic reg_access;
	for (int i = 0; i < 8; i++) apb(1'b1, addr_tab[i], 32'hFFFF_FFFF, 4'hF);
	for (int i = 0; i < 8; i++) begin
		apb(1'b0, addr_tab[i], 32'h0, 4'h0);
		chk("readback", {24'h0, mask_tab[i]}, rd);
		chk("slave error", 1'b0, err);
		apb(1'b1, addr_tab[i], 32'h0, 4'hF);
		apb(1'b0, addr_tab[i], 32'h0, 4'h0);
		chk("cleared", 32'h0, rd);
	end
	apb(1'b1, 12'h024, 32'hFF, 4'hF);
	chk("unmapped write error", 1'b1, err);
	apb(1'b0, 12'h024, 32'h0, 4'h0);
	chk("unmapped read error", 1'b1, err);
	chk("unmapped read data", 32'h0, rd);
	apb(1'b1, `TCE_ADDR_IER1, 32'hFF, 4'h0);
	apb(1'b0, `TCE_ADDR_IER1, 32'h0, 4'h0);
	chk("no byte strobe", 32'h0, rd);
	apb(1'b1, `TCE_ADDR_STAT, 32'hFF, 4'hF);
	apb(1'b0, `TCE_ADDR_STAT, 32'h0, 4'h0);
	chk("status read only", 32'h0, rd);
endtask

// Each pattern enables a different subset of the three counter clears
task automatic counter_clear;
	logic [2:0] pats [3] = '{3'b101, 3'b010, 3'b000};
	for (int i = 0; i < 3; i++) begin
		apb(1'b1, `TCE_ADDR_CLR, {29'h0, pats[i]}, 4'hF);
		settle();
		@(posedge pclk);
		ch5_in <= 6'b111000;
		@(posedge pclk);
		ch5_in <= 6'b000000;
		#1;
		chk("counter clear", {pats[i], 3'b000}, ch5_out);
		@(posedge pclk);
		#1;
		chk("clear is one pulse", 6'h0, ch5_out);
	end
endtask

task automatic channel_gating;
	logic [7:0] pats [2] = '{8'hAA, 8'h55};
	logic [7:0] m;
	tce_chan_req_t [4:0] e;
	for (int ch = 0; ch < 5; ch++) begin
		for (int p = 0; p < 2; p++) begin
			m = pats[p] & mask_tab[ch + 1];
			@(posedge pclk);
			chan_flags <= {5{7'h3F}};
			apb(1'b1, addr_tab[ch + 1], {24'h0, pats[p]}, 4'hF);
			settle();
			e = '0;
			e[ch] = {1'b0, m[5:0]};
			chk("irq gating", e, chan_req);
			@(posedge pclk);
			chan_flags <= {5{7'h3F}} | (35'h40 << (7 * ch));
			ch4_trough_event <= 1'b1;
			@(posedge pclk);
			chan_flags <= {5{7'h3F}};
			ch4_trough_event <= 1'b0;
			#1;
			chk("converter start", m[7], chan_req[ch].conv_start);
			chk("trough start", ch == 4 && m[6], ch4_trough_conv_start);
			@(posedge pclk);
			chan_flags <= '0;
			settle();
			chk("flags dropped", '0, chan_req);
		end
		apb(1'b1, addr_tab[ch + 1], 32'h0, 4'hF);
	end
endtask

task automatic extra_enables;
	@(posedge pclk);
	ch0_match_e_flag <= 1'b1;
	ch0_match_f_flag <= 1'b1;
	ch5_in <= 6'b000111;
	apb(1'b1, `TCE_ADDR_IER0B, 32'hFD, 4'hF);
	apb(1'b1, `TCE_ADDR_IER5, 32'hFD, 4'hF);
	settle();
	chk("second enable irqs", 2'b01, {ch0_match_f_irq, ch0_match_e_irq});
	chk("three phase irqs", 6'b000101, ch5_out);
	apb(1'b1, `TCE_ADDR_IER0B, 32'hFE, 4'hF);
	settle();
	chk("second enable irqs", 2'b10, {ch0_match_f_irq, ch0_match_e_irq});
	@(posedge pclk);
	ch0_match_e_event <= 1'b1;
	@(posedge pclk);
	ch0_match_e_event <= 1'b0;
	#1;
	chk("match e start", 1'b1, ch0_match_e_conv_start);
	@(posedge pclk);
	presetn <= 1'b0;
	@(posedge pclk);
	presetn <= 1'b1;
	#1;
	chk("irqs after reset", 3'b000, {ch0_match_f_irq, ch0_match_e_irq, ch5_out.irq_u});
	apb(1'b0, `TCE_ADDR_IER5, 32'h0, 4'h0);
	chk("enable after reset", 32'h0, rd);
endtask

////////////////////////////////////////////////////////////////////////////////
initial begin
	#200000;
	n_fail++;
	close_out();
end

initial begin
	n_fail = 0;
	samples_checked = 0;
	presetn = 1'b0;
	{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
	chan_flags = '0;
	{ch4_trough_event, ch0_match_e_event, ch0_match_e_flag, ch0_match_f_flag} = '0;
	ch5_in = '0;
	repeat (2) @(posedge pclk);
	presetn <= 1'b1;
	reset_values();
	reg_access();
	counter_clear();
	channel_gating();
	extra_enables();
	close_out();
end
endmodule
